// >>> include/adioem_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * auxiliary digital I/O event block.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
 */
// Overview of operation
// RL1: Each digital output has a function selector, including fixed high and fixed low.
// RL2: Fault function drives 1 once a fault occurred, 0 with no fault.
// RL3: Form function drives 1 for single phase, 0 for split or three phase.
// RL4: Relay function drives 1 while the output relay is enabled, else 0.
// RL5: Program function drives high with a steady-state program, low in manual mode.
// RL6: Remote function drives high under remote control, low under local control.
// RL7: Transient function drives 1 while running, paused or stepping, 0 when stopped.
// RL8: Coupling function drives 1 for transformer coupling, 0 for direct coupling.
// RL9: Each output has its own polarity inversion applied to the selected level.
// RL10: The present level of all four outputs can be read back.
// RL11: Three digital inputs exist and their present levels can be read back.
// RL12: A rising input edge issues that channel's rising command request when stored.
// RL13: A falling input edge issues that channel's falling command request when stored.
// RL14: Each input filter length ranges zero to ten million ms; zero disables filtering.
// RL15: Pulses shorter than the filter length do not register as edges.
// RL16: On relay outputs, uninverted logic 1 turns the driver on, pulling the pin low.
// RL17: Edges come from the filtered level, changed after stability for the length.
// RL18: Inversion follows selection, and readback shows the level actually driven.
`ifndef ADIOEM_REGS_SVH
`define ADIOEM_REGS_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define ADIOEM_OFF_OUT_FUNC   8'h00
`define ADIOEM_OFF_OUT_INV    8'h04
`define ADIOEM_OFF_OUT_STATE  8'h08
`define ADIOEM_OFF_IN_STATE   8'h0c
`define ADIOEM_OFF_CMD_STORED 8'h10
`define ADIOEM_OFF_CMD_PEND   8'h14
`define ADIOEM_OFF_IN_FILT0   8'h20
`define ADIOEM_OFF_IN_FILT1   8'h24
`define ADIOEM_OFF_IN_FILT2   8'h28

// ---------------------------------------------------------------------------
// Field positions and sizes
// ---------------------------------------------------------------------------
`define ADIOEM_FUNC_W        4
`define ADIOEM_NUM_OUT       4
`define ADIOEM_NUM_IN        3
`define ADIOEM_FALL_POS      4
`define ADIOEM_PIN_POS       4
`define ADIOEM_FILT_W        24

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define ADIOEM_RST_OUT_FUNC  16'h0000
`define ADIOEM_RST_OUT_INV   4'h0
`define ADIOEM_RST_STORED    6'h00
`define ADIOEM_RST_FILT      24'h000000
`define ADIOEM_FILT_MAX      24'h989680

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define ADIOEM_CLK_HZ        50000000
`define ADIOEM_TICK_MS       1
`define ADIOEM_TICK_CYCLES   (`ADIOEM_CLK_HZ / 1000 * `ADIOEM_TICK_MS)

`endif

// >>> include/adioem_pkg.sv
/*
 * Types of the auxiliary digital I/O event block.
 * Assumes nothing of its surroundings.
 */
package adioem_pkg;

   // Output function codes.
   typedef enum logic [3:0] {
      ADIOEM_FN_LOW       = 4'h0,
      ADIOEM_FN_HIGH      = 4'h1,
      ADIOEM_FN_FAULT     = 4'h2,
      ADIOEM_FN_FORM      = 4'h3,
      ADIOEM_FN_RELAY     = 4'h4,
      ADIOEM_FN_PROGRAM   = 4'h5,
      ADIOEM_FN_REMOTE    = 4'h6,
      ADIOEM_FN_TRANSIENT = 4'h7,
      ADIOEM_FN_COUPLING  = 4'h8
   } adioem_func_t;

   // Bus slave states.
   typedef enum logic [1:0] {
      ADIOEM_BUS_IDLE = 2'b01,
      ADIOEM_BUS_ACK  = 2'b10
   } adioem_bus_t;

endpackage : adioem_pkg

// >>> core/adioem_in_filter.sv
/*
 * Glitch filter and edge detector for one digital input pin.
 * Assumes an asynchronous pin and a one-cycle millisecond tick from the same clock.
 */
`timescale 1ns/1ps

module adioem_in_filter (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        pin_i,
   input  wire logic        tick_i,
   input  wire logic [23:0] len_i,
   output logic             level_o,
   output logic             rise_o,
   output logic             fall_o
);

   logic        sync1_q;
   logic        sync2_q;
   logic        level_q;
   logic        rise_q;
   logic        fall_q;
   logic [23:0] cnt_q;

   // ------------------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
      end
   end

   // ------------------------------------------------------------------------
   // Stability filter
   // ------------------------------------------------------------------------
   // A level that differs from the accepted one must persist for len_i + 1 ticks, or none when len_i is zero;
   // any return to the accepted level restarts the count, so short pulses die.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_q <= 1'b0;
         cnt_q   <= 24'h000000;
         rise_q  <= 1'b0;
         fall_q  <= 1'b0;
      end else begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         if (sync2_q == level_q) begin
            cnt_q <= 24'h000000; // RL15
         end else if (len_i == 24'h000000 || cnt_q > len_i) begin // RL14
            level_q <= sync2_q; // RL17
            cnt_q   <= 24'h000000;
            rise_q  <= sync2_q; // RL17
            fall_q  <= ~sync2_q; // RL17
         end else if (tick_i) begin
            cnt_q <= cnt_q + 24'h000001;
         end
      end
   end

   assign level_o = level_q;
   assign rise_o  = rise_q;
   assign fall_o  = fall_q;

endmodule : adioem_in_filter

// >>> core/adioem_core.sv
/*
 * Auxiliary digital I/O event block: four selectable digital outputs with
 * polarity inversion and readback, three filtered digital inputs whose edges
 * raise command requests, and a classic Wishbone register slave.
 * Assumes condition inputs come from logic on clk_i; the input pins and the
 * open-drain pad levels are asynchronous.
 */
`timescale 1ns/1ps
`include "adioem_regs.svh"

module adioem_core #(
   parameter int unsigned TICK_CYCLES = `ADIOEM_TICK_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Instrument conditions.
   input  wire logic        fault_i,
   input  wire logic        form_single_i,
   input  wire logic        relay_on_i,
   input  wire logic        program_run_i,
   input  wire logic        remote_i,
   input  wire logic        transient_active_i,
   input  wire logic        xfmr_coupled_i,
   // Digital inputs and command requests.
   input  wire logic [2:0]  din_i,
   output logic      [2:0]  cmd_rise_req_o,
   output logic      [2:0]  cmd_fall_req_o,
   // Digital outputs.
   output logic      [1:0]  dout_o,
   input  wire logic        relay_drive_out_a_i,
   output logic             relay_drive_out_a_o,
   output logic             relay_drive_out_a_oe_o,
   input  wire logic        relay_drive_out_b_i,
   output logic             relay_drive_out_b_o,
   output logic             relay_drive_out_b_oe_o
);

   import adioem_pkg::*;

   // ------------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------------
   function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : byte_merge

   function automatic logic cond_sel(input logic [3:0] fn,
                                     input logic [6:0] cond);
      logic res;
      res = 1'b0;
      case (fn)
         ADIOEM_FN_LOW:       res = 1'b0; // RL1
         ADIOEM_FN_HIGH:      res = 1'b1; // RL1
         ADIOEM_FN_FAULT:     res = cond[0]; // RL2
         ADIOEM_FN_FORM:      res = cond[1]; // RL3
         ADIOEM_FN_RELAY:     res = cond[2]; // RL4
         ADIOEM_FN_PROGRAM:   res = cond[3]; // RL5
         ADIOEM_FN_REMOTE:    res = cond[4]; // RL6
         ADIOEM_FN_TRANSIENT: res = cond[5]; // RL7
         ADIOEM_FN_COUPLING:  res = cond[6]; // RL8
         default:             res = 1'b0;
      endcase
      return res;
   endfunction : cond_sel

   // ------------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------------
   adioem_bus_t  bus_q;
   logic [15:0]  out_func_q;
   logic [3:0]   out_inv_q;
   logic [3:0]   out_lvl_q;
   logic [5:0]   stored_q;
   logic [5:0]   pend_q;
   logic [23:0]  filt_len_q [0:2];
   logic [31:0]  rdata_q;
   logic [15:0]  div_q;
   logic         tick_q;
   logic [1:0]   pad_s1_q;
   logic [1:0]   pad_s2_q;
   logic [2:0]   in_lvl;
   logic [2:0]   in_rise;
   logic [2:0]   in_fall;
   logic [2:0]   rise_req_q;
   logic [2:0]   fall_req_q;
   logic [6:0]   cond;
   logic         take;
   logic         wr;
   logic [31:0]  wmerged;
   logic [31:0]  rdata_d;
   logic [5:0]   pend_set;

   assign cond = {xfmr_coupled_i, transient_active_i, remote_i, program_run_i,
                  relay_on_i, form_single_i, fault_i};
   assign take = wb_cyc_i && wb_stb_i && (bus_q == ADIOEM_BUS_IDLE);
   assign wr   = take && wb_we_i;

   // ------------------------------------------------------------------------
   // Millisecond tick divider
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (div_q >= 16'(TICK_CYCLES - 1)) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Input filters
   // ------------------------------------------------------------------------
   for (genvar i = 0; i < `ADIOEM_NUM_IN; i++) begin : g_in
      adioem_in_filter u_filt (
         .clk_i   (clk_i),
         .rst_i   (rst_i),
         .pin_i   (din_i[i]),
         .tick_i  (tick_q),
         .len_i   (filt_len_q[i]),
         .level_o (in_lvl[i]),
         .rise_o  (in_rise[i]),
         .fall_o  (in_fall[i])
      );
   end

   // ------------------------------------------------------------------------
   // Command requests
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rise_req_q <= 3'h0;
         fall_req_q <= 3'h0;
      end else begin
         rise_req_q <= in_rise & stored_q[2:0]; // RL12
         fall_req_q <= in_fall & stored_q[5:3]; // RL13
      end
   end

   assign cmd_rise_req_o = rise_req_q;
   assign cmd_fall_req_o = fall_req_q;
   assign pend_set = {fall_req_q, rise_req_q};

   // Pending requests stay until software writes a one; a new one wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 6'h00;
      end else if (wr && wb_adr_i == `ADIOEM_OFF_CMD_PEND && wb_sel_i[0]) begin
         pend_q <= (pend_q & ~{wb_dat_i[6:4], wb_dat_i[2:0]}) | pend_set;
      end else begin
         pend_q <= pend_q | pend_set;
      end
   end

   // ------------------------------------------------------------------------
   // Output selection
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_lvl_q <= 4'h0;
      end else begin
         for (int c = 0; c < `ADIOEM_NUM_OUT; c++) begin
            out_lvl_q[c] <= cond_sel(out_func_q[c*4 +: 4], cond) ^ out_inv_q[c]; // RL9 RL18
         end
      end
   end

   assign dout_o                 = out_lvl_q[1:0];
   assign relay_drive_out_a_o    = 1'b0;
   assign relay_drive_out_a_oe_o = out_lvl_q[2]; // RL16
   assign relay_drive_out_b_o    = 1'b0;
   assign relay_drive_out_b_oe_o = out_lvl_q[3]; // RL16

   // Open-drain pad levels, seen after the external pull-up.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_s1_q <= 2'h0;
         pad_s2_q <= 2'h0;
      end else begin
         pad_s1_q <= {relay_drive_out_b_i, relay_drive_out_a_i};
         pad_s2_q <= pad_s1_q;
      end
   end

   // ------------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_func_q <= `ADIOEM_RST_OUT_FUNC;
         out_inv_q  <= `ADIOEM_RST_OUT_INV;
         stored_q   <= `ADIOEM_RST_STORED;
      end else if (wr) begin
         case (wb_adr_i)
            `ADIOEM_OFF_OUT_FUNC:   out_func_q <= wmerged[15:0]; // RL1
            `ADIOEM_OFF_OUT_INV:    out_inv_q  <= wmerged[3:0]; // RL9
            `ADIOEM_OFF_CMD_STORED: stored_q   <= {wmerged[6:4], wmerged[2:0]};
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `ADIOEM_NUM_IN; i++) begin
            filt_len_q[i] <= `ADIOEM_RST_FILT;
         end
      end else if (wr && wb_adr_i >= `ADIOEM_OFF_IN_FILT0
                   && wb_adr_i <= `ADIOEM_OFF_IN_FILT2) begin
         if (wmerged[23:0] > `ADIOEM_FILT_MAX) begin
            filt_len_q[wb_adr_i[3:2]] <= `ADIOEM_FILT_MAX; // RL14
         end else begin
            filt_len_q[wb_adr_i[3:2]] <= wmerged[23:0]; // RL14
         end
      end
   end

   // ------------------------------------------------------------------------
   // Read mux and write merge
   // ------------------------------------------------------------------------
   always_comb begin
      rdata_d = 32'h00000000;
      case (wb_adr_i)
         `ADIOEM_OFF_OUT_FUNC:   rdata_d[15:0] = out_func_q;
         `ADIOEM_OFF_OUT_INV:    rdata_d[3:0]  = out_inv_q;
         `ADIOEM_OFF_OUT_STATE:  rdata_d[5:0]  = {pad_s2_q, out_lvl_q}; // RL10 RL18
         `ADIOEM_OFF_IN_STATE:   rdata_d[2:0]  = in_lvl; // RL11
         `ADIOEM_OFF_CMD_STORED: rdata_d[6:0]  = {stored_q[5:3], 1'b0, stored_q[2:0]};
         `ADIOEM_OFF_CMD_PEND:   rdata_d[6:0]  = {pend_q[5:3], 1'b0, pend_q[2:0]};
         `ADIOEM_OFF_IN_FILT0:   rdata_d[23:0] = filt_len_q[0];
         `ADIOEM_OFF_IN_FILT1:   rdata_d[23:0] = filt_len_q[1];
         `ADIOEM_OFF_IN_FILT2:   rdata_d[23:0] = filt_len_q[2];
         default:                rdata_d       = 32'h00000000;
      endcase
   end

   always_comb begin
      wmerged = byte_merge(rdata_d, wb_dat_i, wb_sel_i);
   end

   // ------------------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------------------
   // Every access, mapped or not, is answered one cycle after it is taken.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_q <= ADIOEM_BUS_IDLE;
      end else begin
         case (bus_q)
            ADIOEM_BUS_IDLE: begin
               if (take) begin
                  bus_q <= ADIOEM_BUS_ACK;
               end
            end
            ADIOEM_BUS_ACK: begin
               bus_q <= ADIOEM_BUS_IDLE;
            end
            default: begin
               bus_q <= ADIOEM_BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h00000000;
      end else if (take && !wb_we_i) begin
         rdata_q <= rdata_d;
      end
   end

   assign wb_ack_o = (bus_q == ADIOEM_BUS_ACK);
   assign wb_dat_o = rdata_q;

endmodule : adioem_core

// >>> test/adioem_chk.sv
/* Port checker for adioem_core: bus answer, output levels, requests.
   Bound to every adioem_core; mirrors the function and invert registers from bus writes. */
`timescale 1ns/1ps
`include "adioem_regs.svh"
module adioem_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        fault_i,
   input wire logic        form_single_i,
   input wire logic        relay_on_i,
   input wire logic        program_run_i,
   input wire logic        remote_i,
   input wire logic        transient_active_i,
   input wire logic        xfmr_coupled_i,
   input wire logic [2:0]  din_i,
   input wire logic [2:0]  cmd_rise_req_o,
   input wire logic [2:0]  cmd_fall_req_o,
   input wire logic [1:0]  dout_o,
   input wire logic        relay_drive_out_a_o,
   input wire logic        relay_drive_out_a_oe_o,
   input wire logic        relay_drive_out_b_o,
   input wire logic        relay_drive_out_b_oe_o
);
   import adioem_pkg::*;
   logic [15:0] fn_q;
   logic [3:0]  inv_q;
   logic [3:0]  lvl;
   logic [6:0]  cnd;
   logic        wr;

   function automatic logic pick(input logic [3:0] k, input logic [6:0] c);
      return (k == ADIOEM_FN_HIGH) ||
             (k >= ADIOEM_FN_FAULT && k <= ADIOEM_FN_COUPLING && c[k - 4'h2]);
   endfunction : pick

   assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign cnd = {xfmr_coupled_i, transient_active_i, remote_i, program_run_i,
                 relay_on_i, form_single_i, fault_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fn_q  <= 16'h0000;
         inv_q <= 4'h0;
      end else if (wr && wb_adr_i == `ADIOEM_OFF_OUT_FUNC) begin
         if (wb_sel_i[0]) fn_q[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) fn_q[15:8] <= wb_dat_i[15:8];
      end else if (wr && wb_adr_i == `ADIOEM_OFF_OUT_INV && wb_sel_i[0]) begin
         inv_q <= wb_dat_i[3:0];
      end
   end

   always_comb begin
      for (int c = 0; c < 4; c++) begin
         lvl[c] = inv_q[c] ^ pick(fn_q[4*c +: 4], cnd);
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property p_ack_lat;
      s_take |=> s_pulse;
   endproperty
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   property p_dat_hold;
      !(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o);
   endproperty
   property p_pins;
      !$past(rst_i) |-> {relay_drive_out_b_oe_o, relay_drive_out_a_oe_o, dout_o} == $past(lvl);
   endproperty
   property p_od_low;
      relay_drive_out_a_o == 1'b0 && relay_drive_out_b_o == 1'b0;
   endproperty
   property p_req_one;
      (cmd_rise_req_o | cmd_fall_req_o) != 3'b000 |=>
         ((cmd_rise_req_o & $past(cmd_rise_req_o)) |
          (cmd_fall_req_o & $past(cmd_fall_req_o))) == 3'b000;
   endproperty
   property p_rise_src;
      (cmd_rise_req_o & ~$past(din_i, 4)) == 3'b000;
   endproperty
   property p_fall_src;
      (cmd_fall_req_o & $past(din_i, 4)) == 3'b000;
   endproperty

   a_ack_lat: assert property (p_ack_lat) else $error("ack not a single pulse after request");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_dat_hold: assert property (p_dat_hold) else $error("read data changed without a read");
   a_pins: assert property (p_pins) else $error("output pin level wrong");
   a_od_low: assert property (p_od_low) else $error("open drain data not low");
   a_req_one: assert property (p_req_one) else $error("request longer than one cycle");
   a_rise_src: assert property (p_rise_src) else $error("rise request without high pin");
   a_fall_src: assert property (p_fall_src) else $error("fall request without low pin");
endmodule : adioem_chk

bind adioem_core adioem_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fault_i, .form_single_i, .relay_on_i,
   .program_run_i, .remote_i, .transient_active_i, .xfmr_coupled_i, .din_i, .cmd_rise_req_o,
   .cmd_fall_req_o, .dout_o, .relay_drive_out_a_o, .relay_drive_out_a_oe_o,
   .relay_drive_out_b_o, .relay_drive_out_b_oe_o);

// >>> test/adioem_plc.sv
/* Model of the external equipment: switch contacts on the inputs, pulled-up relay pads.
   Assumes the bench moves the contacts through set_pin. */
`timescale 1ns/1ps
module adioem_plc (
   input  wire logic       clk_i,
   input  wire logic       od_a_i,
   input  wire logic       od_a_oe_i,
   input  wire logic       od_b_i,
   input  wire logic       od_b_oe_i,
   output logic      [2:0] din_o,
   output logic            pad_a_o,
   output logic            pad_b_o
);
   // A released pad rests at its pull-up level.
   assign pad_a_o = od_a_oe_i ? od_a_i : 1'b1;
   assign pad_b_o = od_b_oe_i ? od_b_i : 1'b1;

   initial din_o = 3'b000;

   task automatic set_pin(input int ch, input logic v);
      @(posedge clk_i);
      din_o[ch] <= v;
   endtask : set_pin
endmodule : adioem_plc

// >>> test/adioem_bench.sv
/* Self-checking bench of adioem_core with the external equipment model.
   Assumes adioem_chk is bound and a tick of 4 clocks stands for one millisecond. */
`timescale 1ns/1ps
`include "adioem_regs.svh"
module adioem_bench;
   import adioem_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack, oa, ob, ea, eb, pa, pb;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [6:0]  cnd;
   logic [2:0]  din, rreq, freq;
   logic [1:0]  dout;
   int          num_errors, tests_run;
   int          nr[3], nf[3];

   adioem_core #(.TICK_CYCLES(4)) u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .fault_i(cnd[0]), .form_single_i(cnd[1]), .relay_on_i(cnd[2]),
      .program_run_i(cnd[3]), .remote_i(cnd[4]), .transient_active_i(cnd[5]),
      .xfmr_coupled_i(cnd[6]), .din_i(din), .cmd_rise_req_o(rreq), .cmd_fall_req_o(freq),
      .dout_o(dout), .relay_drive_out_a_i(pa), .relay_drive_out_a_o(oa),
      .relay_drive_out_a_oe_o(ea), .relay_drive_out_b_i(pb), .relay_drive_out_b_o(ob),
      .relay_drive_out_b_oe_o(eb));
   adioem_plc u_plc (.clk_i, .od_a_i(oa), .od_a_oe_i(ea), .od_b_i(ob), .od_b_oe_i(eb),
      .din_o(din), .pad_a_o(pa), .pad_b_o(pb));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      for (int i = 0; i < 3; i++) begin
         nr[i] += rreq[i];
         nf[i] += freq[i];
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) check(32'h0, 32'h1, "bus answer missing");
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp, what);
   endtask : rd

   task automatic t_reset;
      rd(`ADIOEM_OFF_OUT_FUNC, 32'h0, "function reset");
      rd(`ADIOEM_OFF_OUT_INV, 32'h0, "invert reset");
      rd(`ADIOEM_OFF_CMD_STORED, 32'h0, "stored reset");
      rd(`ADIOEM_OFF_IN_FILT0, 32'h0, "filter reset");
      rd(8'h30, 32'h0, "unmapped read");
      $display("reset test done");
   endtask : t_reset

   task automatic t_outputs;
      logic       e;
      logic [3:0] x, inv;
      for (int p = 0; p < 2; p++) begin
         inv = p ? 4'ha : 4'h5;
         wr(`ADIOEM_OFF_OUT_INV, {28'h0, inv});
         for (int k = 0; k < 10; k++) begin
            wr(`ADIOEM_OFF_OUT_FUNC, {16'h0, {4{4'(k)}}});
            for (int v = 0; v < 2; v++) begin
               cnd <= (k > 1 && k < 9) ? (7'(1 << (k - 2)) ^ {7{~v[0]}}) : {7{v[0]}};
               e = (k == 1) || (k > 1 && k < 9 && v == 1);
               x = {4{e}} ^ inv;
               repeat (4) @(posedge clk_i);
               check({28'h0, eb, ea, dout}, {28'h0, x}, "pin levels");
               rd(`ADIOEM_OFF_OUT_STATE, {26'h0, ~x[3:2], x}, "output state");
            end
         end
      end
      $display("output test done");
   endtask : t_outputs

   task automatic t_edges;
      wr(`ADIOEM_OFF_CMD_STORED, 32'h41);
      nr = '{0, 0, 0};
      nf = '{0, 0, 0};
      for (int c = 0; c < 3; c++) begin
         u_plc.set_pin(c, 1'b1);
         repeat (10) @(posedge clk_i);
         rd(`ADIOEM_OFF_IN_STATE, 32'(1 << c), "input state");
         u_plc.set_pin(c, 1'b0);
         repeat (10) @(posedge clk_i);
      end
      check(nr[0] + 16 * nr[1] + 256 * nr[2], 32'h001, "rise requests");
      check(nf[0] + 16 * nf[1] + 256 * nf[2], 32'h100, "fall requests");
      rd(`ADIOEM_OFF_CMD_PEND, 32'h41, "pending");
      wr(`ADIOEM_OFF_CMD_PEND, 32'h41);
      rd(`ADIOEM_OFF_CMD_PEND, 32'h0, "pending cleared");
      $display("edge test done");
   endtask : t_edges

   task automatic t_filter;
      wr(`ADIOEM_OFF_IN_FILT1, 32'hffffff);
      rd(`ADIOEM_OFF_IN_FILT1, {8'h0, `ADIOEM_FILT_MAX}, "filter clamp");
      wr(`ADIOEM_OFF_IN_FILT0, 32'h3);
      wr(`ADIOEM_OFF_CMD_STORED, 32'h11);
      nr[0] = 0;
      nf[0] = 0;
      u_plc.set_pin(0, 1'b1);
      repeat (10) @(posedge clk_i);
      u_plc.set_pin(0, 1'b0);
      repeat (30) @(posedge clk_i);
      check(nr[0] + nf[0], 32'h0, "short pulse passed");
      u_plc.set_pin(0, 1'b1);
      repeat (6) @(posedge clk_i);
      rd(`ADIOEM_OFF_IN_STATE, 32'h0, "level before filter time");
      repeat (30) @(posedge clk_i);
      rd(`ADIOEM_OFF_IN_STATE, 32'h1, "level after filter time");
      u_plc.set_pin(0, 1'b0);
      repeat (40) @(posedge clk_i);
      check(nr[0] + 16 * nf[0], 32'h11, "filtered edges");
      $display("filter test done");
   endtask : t_filter

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      results;
   end

   initial begin
      num_errors = 0;
      tests_run  = 0;
      rst_i = 1'b1;
      cyc   = 1'b0;
      stb   = 1'b0;
      we    = 1'b0;
      adr   = 8'h00;
      sel   = 4'hf;
      wdat  = 32'h0;
      cnd   = 7'h00;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_outputs;
      t_edges;
      t_filter;
      results;
   end
endmodule : adioem_bench
